// file: bad_decoder.sv
// Address decode, acknowledge, reset distribution and timer clocking of the board
`timescale 1ns/10ps
// Summary of operation
// - ROM sits at top, span by device size
// - ROM expansion doubles ROM window downward
// - RAM at 0-1FFF, or 0-3FFF expanded
// - Fail-safe acknowledge after 10 ms if enabled
// - On-board ROM/RAM acknowledged internally, no bus
// - Off-board: get bus, command, wait acknowledge
// - Power-up reset; first fetch at FFFF0
// - Reset driven to bus init and peripherals
// - Reset idles serial, parallel mode 0 inputs
// - Aux reset whole system, board reset local
// - Parallel ports C8-CC, control CE write-only
// - Timer counters at D0, D2, D4
// - D6 writes mode word, reads do nothing
// - First connector chip selects from A0-BF
// - Three counters, own clock and output
// - Counter 0 to request 2, chain option
// - Counter 2 output is serial baud clock
// - Counter clocks 1.23 MHz and 153.60 kHz
module bad_decoder #(
  parameter int FAILSAFE_CYCLES = bad_pkg::FAILSAFE_CYC
) (
  input  wire logic        clk,
  input  wire logic        sys_rst,
  input  wire logic        clkEn,
  input  wire logic        cpuReq,
  input  wire logic [19:0] cpuAddr,
  input  wire logic        cpuIo,
  input  wire logic        cpuWr,
  input  wire logic        cpuBhe_n,
  output logic             cpuAck,
  output logic             cpuTimedOut,
  output logic             cpuReset,
  output logic             awaitBootFetch,
  input  wire logic [1:0]  romSize,
  input  wire logic        romExpFitted,
  input  wire logic        ramExpFitted,
  input  wire logic        failSafeEn,
  output logic             romSel,
  output logic             ramSel,
  output logic             intrSel,
  output logic             parSel,
  output logic             tmrSel,
  output logic             serSel,
  output logic [1:0]       periphReg,
  output logic             periphRd,
  output logic             periphWr,
  output logic             lowLaneOnly,
  output logic             exp1Cs0_n,
  output logic             exp1Cs1_n,
  output logic             exp2Cs0_n,
  output logic             exp2Cs1_n,
  output logic             busReq,
  input  wire logic        busGrant,
  output logic             busRdCmd,
  output logic             busWrCmd,
  output logic             busIoCmd,
  input  wire logic        busXack,
  input  wire logic        auxReset_n,
  input  wire logic        local_reset_switch_n,
  output logic             busInitOut,
  output logic             periphReset,
  output logic             timerClk0,
  output logic             timerClk1,
  output logic             timerClk2,
  input  wire logic        chainCnt0To1,
  input  wire logic        cnt1OffBoardSel,
  input  wire logic [2:0]  timerOut,
  output logic             interrupt_request_input_2,
  output logic             cnt1ToMatrix,
  output logic             cnt1OffBoard,
  output logic             serialBaudClk
);
  import bad_pkg::*;

  localparam int FS_W = $clog2(FAILSAFE_CYCLES + 1);

  bad_state_t       state_r, state_nxt;
  bad_tgt_t         tgt_r;
  logic [FS_W-1:0]  fsCnt_r;
  logic             sysRst_r, brdRst_r;
  logic [8:0]       divFast_r;
  logic [8:0]       divSlow_r;
  logic             tickFast, tickSlow;
  logic             take;

  // Memory decode, shared by the sequencer and the checks
  function automatic bad_tgt_t memDecode(input logic [19:0] a, input logic [1:0] sz,
                                         input logic romX, input logic ramX);
    logic [20:0] span;
    // Shift amount kept at three bits so 64K with expansion reaches four
    span = ROM_SPAN_MIN << ({1'b0, sz} + {2'b00, romX});
    memDecode = TGT_BUSMEM;
    if ({1'b0, a} >= MEM_TOP - span)
      memDecode = TGT_ROM;
    else if (a <= (ramX ? RAM_TOP_EXP : RAM_TOP_BASE))
      memDecode = TGT_RAM;
  endfunction

  // I/O decode; odd peripheral ports and odd connector ports with A4 set are not decoded on-board
  function automatic bad_tgt_t ioDecode(input logic [19:0] a);
    ioDecode = TGT_BUSIO;
    if (a[19:8] == 12'h000) begin
      if (a[7:5] == IO_GRP_EXP2)
        ioDecode = (a[4] && a[0]) ? TGT_BUSIO : TGT_EXP2;
      else if (a[7:5] == IO_GRP_EXP1)
        ioDecode = (a[4] && a[0]) ? TGT_BUSIO : TGT_EXP1;
      else if (!a[0]) begin
        case (a[7:3])
          IO_GRP_INTR: ioDecode = TGT_INTR;
          IO_GRP_PAR:  ioDecode = TGT_PAR;
          IO_GRP_TMR:  ioDecode = TGT_TMR;
          IO_GRP_SER:  ioDecode = TGT_SER;
          default:     ioDecode = TGT_BUSIO;
        endcase
      end
    end
  endfunction

  function automatic bad_tgt_t decodeAll(input logic [19:0] a, input logic io,
                                         input logic [1:0] sz, input logic romX,
                                         input logic ramX);
    decodeAll = io ? ioDecode(a) : memDecode(a, sz, romX, ramX);
  endfunction

  // Request taken only in idle, so a held request is not retaken until its cycle has returned to idle
  assign take = clkEn && cpuReq && (state_r == ST_IDLE) && !brdRst_r;

  // Reset sources; aux reaches other boards, the local switch stays here
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sysRst_r <= 1'b1;
      brdRst_r <= 1'b1;
    end else if (clkEn) begin
      sysRst_r <= !auxReset_n;
      brdRst_r <= !auxReset_n || !local_reset_switch_n;
    end
  end

  // Reset fan-out: processor, bus init line and on-board peripherals
  assign cpuReset    = brdRst_r;
  assign busInitOut  = sysRst_r;
  assign periphReset = brdRst_r;

  // First fetch after reset is expected at the reset vector in ROM
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      awaitBootFetch <= 1'b1;
    else if (clkEn) begin
      if (brdRst_r)
        awaitBootFetch <= 1'b1;
      else if (take && !cpuIo && cpuAddr == RESET_VECTOR)
        awaitBootFetch <= 1'b0;
    end
  end

  // Sequencer next state
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (take) begin
          case (decodeAll(cpuAddr, cpuIo, romSize, romExpFitted, ramExpFitted))
            TGT_BUSMEM, TGT_BUSIO: state_nxt = ST_BUSREQ;
            default:               state_nxt = ST_LOCAL;
          endcase
        end
      end
      ST_LOCAL:  state_nxt = ST_ACK;
      ST_BUSREQ: begin
        if (busGrant)
          state_nxt = ST_BUSCMD;
        else if (failSafeEn && fsCnt_r >= FS_W'(FAILSAFE_CYCLES))
          state_nxt = ST_ACK;
      end
      ST_BUSCMD: begin
        if (busXack)
          state_nxt = ST_ACK;
        else if (failSafeEn && fsCnt_r >= FS_W'(FAILSAFE_CYCLES))
          state_nxt = ST_ACK;
      end
      ST_ACK:    state_nxt = ST_IDLE;
      default:   state_nxt = ST_IDLE;
    endcase
  end

  // Sequencer state; a reset aborts any cycle in flight
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      state_r <= ST_IDLE;
    else if (clkEn)
      state_r <= brdRst_r ? ST_IDLE : state_nxt;
  end

  // Fail-safe counter runs only while waiting on the bus
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      fsCnt_r <= '0;
    else if (clkEn) begin
      if (state_r == ST_BUSREQ || state_r == ST_BUSCMD)
        fsCnt_r <= fsCnt_r + FS_W'(1);
      else
        fsCnt_r <= '0;
    end
  end

  // Timeout flag stands with the acknowledge it explains
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      cpuTimedOut <= 1'b0;
    else if (clkEn) begin
      if ((state_r == ST_BUSREQ || state_r == ST_BUSCMD) && state_nxt == ST_ACK)
        cpuTimedOut <= !(state_r == ST_BUSCMD && busXack);
      else if (state_r == ST_ACK)
        cpuTimedOut <= 1'b0;
    end
  end

  // Acknowledge is a one-cycle pulse in the ack state
  assign cpuAck = clkEn && (state_r == ST_ACK);

  // Bus ownership and commands; command only once the bus is ours
  assign busReq   = (state_r == ST_BUSREQ) || (state_r == ST_BUSCMD);
  assign busRdCmd = (state_r == ST_BUSCMD) && !cpuWr;
  assign busWrCmd = (state_r == ST_BUSCMD) && cpuWr;
  assign busIoCmd = (state_r == ST_BUSCMD) && (tgt_r == TGT_BUSIO);

  // Target and selects latched at take, dropped after the acknowledge
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tgt_r       <= TGT_NONE;
      romSel      <= 1'b0;
      ramSel      <= 1'b0;
      intrSel     <= 1'b0;
      parSel      <= 1'b0;
      tmrSel      <= 1'b0;
      serSel      <= 1'b0;
      periphReg   <= 2'h0;
      periphRd    <= 1'b0;
      periphWr    <= 1'b0;
      lowLaneOnly <= 1'b0;
      exp1Cs0_n   <= 1'b1;
      exp1Cs1_n   <= 1'b1;
      exp2Cs0_n   <= 1'b1;
      exp2Cs1_n   <= 1'b1;
    end else if (clkEn) begin
      if (take) begin : latchSel
        bad_tgt_t t;
        logic     wo;
        logic     cs0;
        logic     cs1;
        t   = decodeAll(cpuAddr, cpuIo, romSize, romExpFitted, ramExpFitted);
        // Write-only control words answer a read with nothing
        wo  = ((t == TGT_PAR) || (t == TGT_TMR)) && (cpuAddr[2:1] == REG_WO)
              && !cpuWr;
        cs0 = !cpuAddr[4] && !cpuAddr[0];
        cs1 = cpuAddr[4] ? !cpuAddr[0] : cpuAddr[0];
        tgt_r       <= t;
        romSel      <= (t == TGT_ROM);
        ramSel      <= (t == TGT_RAM);
        intrSel     <= (t == TGT_INTR);
        parSel      <= (t == TGT_PAR) && !wo;
        tmrSel      <= (t == TGT_TMR) && !wo;
        serSel      <= (t == TGT_SER);
        periphReg   <= (t == TGT_INTR || t == TGT_SER) ? {1'b0, cpuAddr[1]}
                                                       : cpuAddr[2:1];
        periphRd    <= (t >= TGT_INTR && t <= TGT_SER) && !cpuWr && !wo;
        periphWr    <= (t >= TGT_INTR && t <= TGT_SER) && cpuWr;
        lowLaneOnly <= (t >= TGT_INTR && t <= TGT_SER);
        exp1Cs0_n   <= !((t == TGT_EXP1) && cs0);
        exp1Cs1_n   <= !((t == TGT_EXP1) && cs1);
        exp2Cs0_n   <= !((t == TGT_EXP2) && cs0);
        exp2Cs1_n   <= !((t == TGT_EXP2) && cs1);
      end else if (state_r == ST_ACK || brdRst_r) begin
        tgt_r       <= TGT_NONE;
        romSel      <= 1'b0;
        ramSel      <= 1'b0;
        intrSel     <= 1'b0;
        parSel      <= 1'b0;
        tmrSel      <= 1'b0;
        serSel      <= 1'b0;
        periphRd    <= 1'b0;
        periphWr    <= 1'b0;
        lowLaneOnly <= 1'b0;
        exp1Cs0_n   <= 1'b1;
        exp1Cs1_n   <= 1'b1;
        exp2Cs0_n   <= 1'b1;
        exp2Cs1_n   <= 1'b1;
      end
    end
  end

  // Counter clock dividers; ratios round down, so rates sit slightly high
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      divFast_r <= '0;
      divSlow_r <= '0;
    end else if (clkEn) begin
      divFast_r <= tickFast ? '0 : divFast_r + 9'(1);
      divSlow_r <= tickSlow ? '0 : divSlow_r + 9'(1);
    end
  end
  assign tickFast = (divFast_r == 9'(TDIV_FAST - 1));
  assign tickSlow = (divSlow_r == 9'(TDIV_SLOW - 1));

  // Each counter gets its own clock; counter 1 may chain off counter 0
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timerClk0                 <= 1'b0;
      timerClk1                 <= 1'b0;
      timerClk2                 <= 1'b0;
      interrupt_request_input_2 <= 1'b0;
      cnt1ToMatrix              <= 1'b0;
      cnt1OffBoard              <= 1'b0;
      serialBaudClk             <= 1'b0;
    end else if (clkEn) begin
      timerClk0                 <= tickFast;
      timerClk1                 <= chainCnt0To1 ? timerOut[0] : tickSlow;
      timerClk2                 <= tickFast;
      interrupt_request_input_2 <= timerOut[0];
      cnt1ToMatrix              <= !cnt1OffBoardSel && timerOut[1];
      cnt1OffBoard              <= cnt1OffBoardSel && timerOut[1];
      serialBaudClk             <= timerOut[2];
    end
  end

  // Checks
  sequence s_onboardTake;
    take && !cpuIo && (memDecode(cpuAddr, romSize, romExpFitted, ramExpFitted) != TGT_BUSMEM);
  endsequence
  sequence s_localAck;
    clkEn [*2] ##1 cpuAck;
  endsequence

  a_onboard_ack: assert property (@(posedge clk) disable iff (sys_rst || brdRst_r)
    s_onboardTake ##0 (clkEn [*2]) |-> ##1 (cpuAck && !busReq))
    else $error("on-board access not acknowledged locally");
  a_rom_hit_sel: assert property (@(posedge clk) disable iff (sys_rst)
    take && !cpuIo && {1'b0, cpuAddr} >= (MEM_TOP - (ROM_SPAN_MIN << ({1'b0, romSize}
      + {2'b00, romExpFitted}))) |=> romSel)
    else $error("ROM window address missed");
  a_ram_hit_sel: assert property (@(posedge clk) disable iff (sys_rst)
    take && !cpuIo && cpuAddr <= RAM_TOP_BASE |=> ramSel)
    else $error("low RAM address missed");
  a_cmd_needs_grant: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(busRdCmd || busWrCmd) |-> $past(busGrant) && busReq)
    else $error("bus command without grant");
  a_xack_ends_cmd: assert property (@(posedge clk) disable iff (sys_rst || brdRst_r)
    (state_r == ST_BUSCMD) && busXack && clkEn |=> cpuAck && !cpuTimedOut)
    else $error("transfer acknowledge not passed on");
  a_failsafe_fire: assert property (@(posedge clk) disable iff (sys_rst || brdRst_r)
    busReq && failSafeEn && clkEn && fsCnt_r >= FS_W'(FAILSAFE_CYCLES)
      && !(state_r == ST_BUSREQ && busGrant) && !busXack
      |=> cpuAck && cpuTimedOut)
    else $error("fail-safe acknowledge missing");
  a_no_fs_stall: assert property (@(posedge clk) disable iff (sys_rst || brdRst_r)
    busReq && !failSafeEn && !busXack && !(state_r == ST_BUSREQ && busGrant)
      |=> !cpuAck)
    else $error("acknowledge without bus or fail-safe");
  a_wo_read_quiet: assert property (@(posedge clk) disable iff (sys_rst)
    take && cpuIo && !cpuWr && (cpuAddr == {12'h000, IO_TMR_MODE}
      || cpuAddr == {12'h000, IO_PAR_CTRL}) |=> !periphRd && !tmrSel && !parSel)
    else $error("write-only port answered a read");
  a_exp_cs_excl: assert property (@(posedge clk) disable iff (sys_rst)
    take && cpuIo && cpuAddr[19:8] == 12'h000 && cpuAddr[7:5] == IO_GRP_EXP1
      && !cpuAddr[4] && !cpuAddr[0] |=> !exp1Cs0_n && exp1Cs1_n)
    else $error("first connector low select wrong");
  a_exp2_8bit: assert property (@(posedge clk) disable iff (sys_rst)
    take && cpuIo && cpuAddr[19:8] == 12'h000 && cpuAddr[7:5] == IO_GRP_EXP2
      && cpuAddr[4] && !cpuAddr[0] |=> exp2Cs0_n && !exp2Cs1_n)
    else $error("second connector byte select wrong");
  a_reset_fanout: assert property (@(posedge clk) disable iff (sys_rst)
    sysRst_r |-> brdRst_r && periphReset && cpuReset)
    else $error("system reset not distributed");
  a_irq2_route: assert property (@(posedge clk) disable iff (sys_rst)
    clkEn |=> interrupt_request_input_2 == $past(timerOut[0]))
    else $error("counter 0 not on request 2");
  a_fast_tick: assert property (@(posedge clk) disable iff (sys_rst)
    tickFast && clkEn |=> !tickFast)
    else $error("fast counter clock stuck");
endmodule

// file: bad_pkg.sv
// Shared constants and types of the board address decoder
package bad_pkg;
  // Clock and timing
  localparam int CLK_HZ         = 50_000_000;
  localparam int CLK_NS         = 20;
  localparam int FAILSAFE_MS    = 10;
  localparam int FAILSAFE_CYC   = (FAILSAFE_MS * 1_000_000) / CLK_NS;
  localparam int TCLK_FAST_HZ   = 1_230_000;
  localparam int TCLK_SLOW_HZ   = 153_600;
  localparam int TDIV_FAST      = CLK_HZ / TCLK_FAST_HZ;
  localparam int TDIV_SLOW      = CLK_HZ / TCLK_SLOW_HZ;
  // Memory map
  localparam logic [20:0] MEM_TOP      = 21'h100000;
  localparam logic [20:0] ROM_SPAN_MIN = 21'h002000;
  localparam logic [19:0] RAM_TOP_BASE = 20'h01fff;
  localparam logic [19:0] RAM_TOP_EXP  = 20'h03fff;
  localparam logic [19:0] RESET_VECTOR = 20'hffff0;
  // I/O map, groups on the upper five or three address bits and register offsets
  localparam logic [7:0] IO_INTR_CMD   = 8'hc0;
  localparam logic [7:0] IO_INTR_MASK  = 8'hc2;
  localparam logic [7:0] IO_PAR_A      = 8'hc8;
  localparam logic [7:0] IO_PAR_B      = 8'hca;
  localparam logic [7:0] IO_PAR_C      = 8'hcc;
  localparam logic [7:0] IO_PAR_CTRL   = 8'hce;
  localparam logic [7:0] IO_TMR_CNT0   = 8'hd0;
  localparam logic [7:0] IO_TMR_CNT1   = 8'hd2;
  localparam logic [7:0] IO_TMR_CNT2   = 8'hd4;
  localparam logic [7:0] IO_TMR_MODE   = 8'hd6;
  localparam logic [7:0] IO_SER_DATA   = 8'hd8;
  localparam logic [7:0] IO_SER_CMD    = 8'hda;
  localparam logic [4:0] IO_GRP_INTR   = 5'h18;
  localparam logic [4:0] IO_GRP_PAR    = 5'h19;
  localparam logic [4:0] IO_GRP_TMR    = 5'h1a;
  localparam logic [4:0] IO_GRP_SER    = 5'h1b;
  localparam logic [2:0] IO_GRP_EXP2   = 3'h4;
  localparam logic [2:0] IO_GRP_EXP1   = 3'h5;
  localparam logic [1:0] REG_WO        = 2'h3;
  // Decode targets
  typedef enum logic [3:0] {
    TGT_NONE, TGT_ROM, TGT_RAM, TGT_BUSMEM, TGT_INTR, TGT_PAR,
    TGT_TMR, TGT_SER, TGT_EXP1, TGT_EXP2, TGT_BUSIO
  } bad_tgt_t;
  // Cycle sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_LOCAL, ST_BUSREQ, ST_BUSCMD, ST_ACK
  } bad_state_t;
endpackage

// file: bad_bus_mem.sv
// Behavioural system bus arbiter and memory facing the decoder
`timescale 1ns/10ps
module bad_bus_mem (
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       busReq,
  input  wire logic       busRdCmd,
  input  wire logic       busWrCmd,
  input  wire logic       present,
  input  wire logic [3:0] lag,
  output logic            busGrant,
  output logic            busXack
);
  logic [3:0] reqCnt;
  logic [3:0] cmdCnt;
  // Cycles spent waiting, saturating so a stuck cycle never wraps
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reqCnt <= 4'h0;
      cmdCnt <= 4'h0;
    end else begin
      reqCnt <= !busReq ? 4'h0 : (reqCnt == 4'hf) ? reqCnt : reqCnt + 4'h1;
      cmdCnt <= !(busRdCmd | busWrCmd) ? 4'h0 : (cmdCnt == 4'hf) ? cmdCnt : cmdCnt + 4'h1;
    end
  end
  // Grant held once given; absent memory never acknowledges
  assign busGrant = busReq && (reqCnt >= lag);
  assign busXack  = present && (busRdCmd | busWrCmd) && (cmdCnt >= lag);
endmodule

// file: testbench.sv
// Self-checking bench for the board address decoder
`timescale 1ns/10ps
module testbench;
  import bad_pkg::*;
  localparam int FS = 20;
  logic clk = 1'b0, sys_rst = 1'b1, cpuReq = 1'b0, cpuIo = 1'b0, cpuWr = 1'b0;
  logic [19:0] cpuAddr = 20'h00000;
  logic [1:0] romSize = 2'h0;
  logic romExpFitted = 1'b0, ramExpFitted = 1'b0, failSafeEn = 1'b1, present = 1'b1;
  logic auxReset_n = 1'b1, local_reset_switch_n = 1'b1, chainCnt0To1 = 1'b0, cnt1Sel = 1'b0;
  logic [2:0] timerOut = 3'h0;
  logic [3:0] lag = 4'h0;
  logic cpuAck, cpuTimedOut, cpuReset, awaitBootFetch, romSel, ramSel, intrSel, parSel;
  logic tmrSel, serSel, periphRd, periphWr, lowLaneOnly, exp1Cs0_n, exp1Cs1_n, exp2Cs0_n;
  logic exp2Cs1_n, busReq, busGrant, busRdCmd, busWrCmd, busIoCmd, busXack, busInitOut;
  logic periphReset, timerClk0, timerClk1, timerClk2, irq2, cnt1ToMatrix, cnt1OffBoard, baud;
  logic [1:0] periphReg;
  logic [9:0] sel;
  logic [4:0] per;
  logic [2:0] cmdKind;
  logic viaBus, tmo;
  int lat, failCount = 0, checksDone = 0;
  bad_decoder #(.FAILSAFE_CYCLES(FS)) u_dut (.clk(clk), .sys_rst(sys_rst), .clkEn(1'b1),
    .cpuReq(cpuReq), .cpuAddr(cpuAddr), .cpuIo(cpuIo), .cpuWr(cpuWr), .cpuBhe_n(1'b1),
    .cpuAck(cpuAck), .cpuTimedOut(cpuTimedOut), .cpuReset(cpuReset),
    .awaitBootFetch(awaitBootFetch), .romSize(romSize), .romExpFitted(romExpFitted),
    .ramExpFitted(ramExpFitted), .failSafeEn(failSafeEn), .romSel(romSel), .ramSel(ramSel),
    .intrSel(intrSel), .parSel(parSel), .tmrSel(tmrSel), .serSel(serSel),
    .periphReg(periphReg), .periphRd(periphRd), .periphWr(periphWr),
    .lowLaneOnly(lowLaneOnly), .exp1Cs0_n(exp1Cs0_n), .exp1Cs1_n(exp1Cs1_n),
    .exp2Cs0_n(exp2Cs0_n), .exp2Cs1_n(exp2Cs1_n), .busReq(busReq), .busGrant(busGrant),
    .busRdCmd(busRdCmd), .busWrCmd(busWrCmd), .busIoCmd(busIoCmd), .busXack(busXack),
    .auxReset_n(auxReset_n), .local_reset_switch_n(local_reset_switch_n),
    .busInitOut(busInitOut), .periphReset(periphReset), .timerClk0(timerClk0),
    .timerClk1(timerClk1), .timerClk2(timerClk2), .chainCnt0To1(chainCnt0To1),
    .cnt1OffBoardSel(cnt1Sel), .timerOut(timerOut), .interrupt_request_input_2(irq2),
    .cnt1ToMatrix(cnt1ToMatrix), .cnt1OffBoard(cnt1OffBoard), .serialBaudClk(baud));
  bad_bus_mem u_mem (.clk(clk), .sys_rst(sys_rst), .busReq(busReq), .busRdCmd(busRdCmd),
    .busWrCmd(busWrCmd), .present(present), .lag(lag), .busGrant(busGrant),
    .busXack(busXack));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One processor cycle, entered at a falling edge; request held until ack is past
  task automatic access(input logic [19:0] a, input logic io, input logic wr,
                        input logic mustAck, input int maxw);
    logic granted;
    granted = 1'b0;
    viaBus = 1'b0;
    cmdKind = 3'h0;
    lat = -1;
    {cpuAddr, cpuIo, cpuWr, cpuReq} = {a, io, wr, 1'b1};
    for (int i = 1; i <= maxw && lat < 0; i++) begin
      @(negedge clk);
      if (i == 1) sel = {romSel, ramSel, intrSel, parSel, tmrSel, serSel, exp1Cs0_n,
                         exp1Cs1_n, exp2Cs0_n, exp2Cs1_n};
      if (i == 1) per = {periphReg, periphRd, periphWr, lowLaneOnly};
      if ((busRdCmd | busWrCmd) === 1'b1) check("cmd after grant", granted, 1);
      if ((busRdCmd | busWrCmd) === 1'b1) cmdKind = {busRdCmd, busWrCmd, busIoCmd};
      if (busGrant === 1'b1) granted = 1'b1;
      if (busReq === 1'b1) viaBus = 1'b1;
      if (cpuAck === 1'b1) tmo = cpuTimedOut;
      if (cpuAck === 1'b1) lat = i;
    end
    @(negedge clk);
    cpuReq = 1'b0;
    // One idle edge so a following call never re-raises the request at once
    @(negedge clk);
    if (lat < 0 && mustAck) begin
      failCount++;
      end_of_test();
    end
  endtask
  task automatic t_reset();
    sys_rst = 1'b1;
    repeat (8) @(negedge clk);
    check("reset outs", {cpuReset, busInitOut, periphReset, awaitBootFetch}, 4'hf);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    check("reset gone", {cpuReset, busInitOut, periphReset}, 3'h0);
  endtask
  task automatic t_boot();
    access(RESET_VECTOR, 1'b0, 1'b0, 1'b1, 20);
    check("boot rom", {sel[9:8], viaBus, awaitBootFetch}, 4'h8);
    check("boot ack", lat, 2);
  endtask
  task automatic t_rom_map();
    logic [20:0] base;
    for (int x = 0; x < 2; x++) begin
      for (int s = 0; s < 4; s++) begin
        {romExpFitted, romSize} = {x[0], s[1:0]};
        base = MEM_TOP - (ROM_SPAN_MIN << (s + x));
        access(base[19:0], 1'b0, 1'b0, 1'b1, 40);
        check("rom base", {sel[9], viaBus}, 2'b10);
        access(base[19:0] - 20'h1, 1'b0, 1'b1, 1'b1, 40);
        check("below rom", {sel[9], viaBus}, 2'b01);
      end
    end
  endtask
  task automatic t_ram_map();
    logic [19:0] top;
    for (int x = 0; x < 2; x++) begin
      ramExpFitted = x[0];
      top = x ? RAM_TOP_EXP : RAM_TOP_BASE;
      access(top, 1'b0, 1'b1, 1'b1, 40);
      check("ram top", {sel[8], viaBus}, 2'b10);
      check("ram ack", lat, 2);
      access(top + 20'h1, 1'b0, 1'b0, 1'b1, 40);
      check("above ram", {sel[8], viaBus}, 2'b01);
    end
  endtask
  task automatic t_io_map();
    logic [7:0] p;
    logic [3:0] grp;
    logic [1:0] r;
    logic wo;
    for (int i = 0; i < 16; i++) begin
      p = 8'hc0 + 8'(2 * i);
      grp = 4'h8 >> (p[7:3] - 5'h18);
      r = (p[4] == p[3]) ? {1'b0, p[1]} : p[2:1];
      wo = (p == 8'hce || p == 8'hd6);
      access({12'h000, p}, 1'b1, 1'b1, 1'b1, 20);
      check("io write", {sel[7:4], per, viaBus}, {grp, r, 3'b011, 1'b0});
      access({12'h000, p}, 1'b1, 1'b0, 1'b1, 20);
      check("io read", {sel[7:4], per[2:1], viaBus}, wo ? 7'h0 : {grp, 3'b100});
      check("io ack", lat, 2);
    end
  endtask
  task automatic t_exp();
    logic [7:0] ports [8] = '{8'h80, 8'h81, 8'h90, 8'h9e, 8'ha0, 8'haf, 8'hb0, 8'hbe};
    logic [3:0] cs [8] = '{4'hd, 4'he, 4'he, 4'he, 4'h7, 4'hb, 4'hb, 4'hb};
    for (int i = 0; i < 8; i++) begin
      access({12'h000, ports[i]}, 1'b1, i[0], 1'b1, 20);
      check("exp cs", {sel[3:0], viaBus}, {cs[i], 1'b0});
      check("exp ack", lat, 2);
    end
  endtask
  task automatic t_bus();
    lag = 4'h3;
    access(20'h50000, 1'b0, 1'b1, 1'b1, 60);
    check("slow bus", {viaBus, cmdKind}, 4'ha);
    check("slow lat", lat, 9);
    lag = 4'h0;
    access(20'h000c1, 1'b1, 1'b0, 1'b1, 60);
    check("bus io", {viaBus, cmdKind, lat[3:0]}, {4'hd, 4'h3});
  endtask
  task automatic t_failsafe();
    present = 1'b0;
    access(20'h40000, 1'b0, 1'b0, 1'b1, FS + 20);
    check("fs window", (lat > FS) && (lat <= FS + 4), 1);
    check("fs flag", tmo, 1'b1);
    failSafeEn = 1'b0;
    access(20'h40000, 1'b0, 1'b0, 1'b0, 4 * FS);
    check("stalls", lat, -1);
    t_reset();
    check("boot again", awaitBootFetch, 1'b1);
    {present, failSafeEn} = 2'b11;
  endtask
  task automatic t_ext_reset();
    auxReset_n = 1'b0;
    @(negedge clk);
    check("aux reset", {busInitOut, cpuReset}, 2'b11);
    {auxReset_n, local_reset_switch_n} = 2'b10;
    repeat (2) @(negedge clk);
    check("board reset", {busInitOut, cpuReset, periphReset}, 3'b011);
    local_reset_switch_n = 1'b1;
    repeat (2) @(negedge clk);
    check("resets off", {busInitOut, cpuReset, periphReset}, 3'b000);
  endtask
  task automatic t_timers();
    int n0, n1, n2;
    {n0, n1, n2} = {32'd0, 32'd0, 32'd0};
    for (int i = 0; i < TDIV_SLOW * 2; i++) begin
      @(negedge clk);
      n0 += (i < TDIV_FAST * 10) ? int'(timerClk0) : 0;
      n2 += (i < TDIV_FAST * 10) ? int'(timerClk2) : 0;
      n1 += int'(timerClk1);
    end
    check("clk fast", {n0[7:0], n2[7:0]}, {8'd10, 8'd10});
    check("clk slow", n1, 2);
    {chainCnt0To1, timerOut} = 4'hd;
    repeat (2) @(negedge clk);
    check("outs high", {irq2, baud, timerClk1}, 3'h7);
    timerOut = 3'h0;
    repeat (2) @(negedge clk);
    check("outs low", {irq2, baud, timerClk1}, 3'h0);
    {cnt1Sel, timerOut} = 4'ha;
    repeat (2) @(negedge clk);
    check("cnt1 off board", {cnt1OffBoard, cnt1ToMatrix}, 2'b10);
    cnt1Sel = 1'b0;
    repeat (2) @(negedge clk);
    check("cnt1 to matrix", {cnt1OffBoard, cnt1ToMatrix}, 2'b01);
  endtask
  // Main sequence
  initial begin
    t_reset();
    t_boot();
    t_rom_map();
    t_ram_map();
    t_io_map();
    t_exp();
    t_bus();
    t_failsafe();
    t_ext_reset();
    t_timers();
    end_of_test();
  end
endmodule
